// File: pkg/gpfmc_pkg.sv
// What this block does
// RL1: Upper nibble picks pin two, resets lock
// RL2: Lower nibble picks pin one, resets automute
// RL3: Code 0 drives automute status
// RL4: Code 1 drives loop lock status
// RL5: Code 2 drives both-channels minimum volume
// RL6: Code 4 interrupts on lock change
// RL7: Code 5 interrupts on automute change
// RL8: Code 6 interrupts on either change
// RL9: Code 8 samples pin for readback
// RL10: Code 9 pin steers input selection
// RL11: Master enable bit drives serial clocks
// RL12: Bit clock divides reference by 4/8/16/16
// RL13: Frame clock is bit clock over 64
// RL14: Master drives clock and first data pin
// RL15: Quick lock enable bit
// RL16: Host sets quick lock only for PCM
// RL17: Lock wait is 16384 over code+1
// RL18: Host enables master only for serial format
// RL19: Host uses longest wait above 96kHz
// RL20: Pin and master registers reset values
// RL21: Reserved register nine reads/writes, 0x22
// RL22: Codes 3 clock, 7 low, 15 high
// RL23: Automute inactive when time setting zero
package gpfmc_pkg;

	localparam int unsigned REG_W = 8;
	localparam int unsigned WAIT_W = 15;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_PIN_FUNC   = 6'h08;
	localparam logic [5:0] IDX_RSVD_NINE  = 6'h09;
	localparam logic [5:0] IDX_CLK_MASTER = 6'h0a;
	localparam logic [5:0] IDX_PIN_STATE  = 6'h30;

	localparam logic [7:0] PIN_FUNC_RST   = 8'h10;
	localparam logic [7:0] RSVD_NINE_RST  = 8'h22;
	localparam logic [7:0] CLK_MASTER_RST = 8'h05;

	localparam int unsigned WAIT_BASE = 16384;
	localparam logic [4:0]  BITS_PER_HALF_FRAME = 5'h1f;
	localparam logic [3:0]  HALF_DIV4  = 4'h2;
	localparam logic [3:0]  HALF_DIV8  = 4'h4;
	localparam logic [3:0]  HALF_DIV16 = 4'h8;

	typedef enum logic [3:0] {
		FN_AUTOMUTE = 4'h0,
		FN_LOCK     = 4'h1,
		FN_MIN_VOL  = 4'h2,
		FN_REF_CLK  = 4'h3,
		FN_INT_LOCK = 4'h4,
		FN_INT_MUTE = 4'h5,
		FN_INT_ANY  = 4'h6,
		FN_LOW      = 4'h7,
		FN_INPUT    = 4'h8,
		FN_IN_SEL   = 4'h9,
		FN_HIGH     = 4'hf
	} gpfmc_func_e;

	typedef struct packed {
		logic [3:0] pin_two_function;
		logic [3:0] pin_one_function;
	} gpfmc_pin_func_s;

	typedef struct packed {
		logic       master_en;
		logic [1:0] div_sel;
		logic       quick_lock;
		logic [3:0] lock_wait;
	} gpfmc_clk_master_s;

	typedef struct packed {
		logic min_volume;
		logic automute;
		logic lock;
	} gpfmc_stat_s;

	typedef struct packed {
		logic level;
		logic oe;
	} gpfmc_pin_s;

	typedef struct packed {
		logic       master_en;
		logic       min_volume;
		logic       automute;
		logic       lock;
		logic [1:0] pin_level;
		logic [1:0] irq;
	} gpfmc_pin_state_s;

	function automatic logic [WAIT_W-1:0] gpfmc_lock_wait(input logic [3:0] code);
		gpfmc_lock_wait = WAIT_W'(WAIT_BASE / (int'(code) + 1));
	endfunction

	function automatic logic [3:0] gpfmc_half_period(input logic [1:0] sel);
		case (sel)
			2'h0:    gpfmc_half_period = HALF_DIV4;
			2'h1:    gpfmc_half_period = HALF_DIV8;
			default: gpfmc_half_period = HALF_DIV16;
		endcase
	endfunction

endpackage

// File: verif/gpfmc_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module gpfmc_assertions
	import gpfmc_pkg::*;
#(
	parameter int unsigned WB_DATA_W = 32
)
(
	input wire logic                 mclk_in,
	input wire logic                 rst_in,
	input wire logic                 wb_cyc_in,
	input wire logic                 wb_stb_in,
	input wire logic                 wb_ack_out,
	input wire logic [WB_DATA_W-1:0] wb_dat_out,
	input wire gpfmc_pin_s           pin_one_out,
	input wire gpfmc_pin_s           serial_clk_out,
	input wire gpfmc_pin_s           first_serial_pin_out,
	input wire logic [1:0]           pin_level_out,
	input wire logic [1:0]           in_select_en_out,
	input wire logic [1:0]           in_select_level_out,
	input wire logic [WAIT_W-1:0]    lock_wait_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	sequence s_req;
		wb_cyc_in && wb_stb_in && !wb_ack_out;
	endsequence
	sequence s_pulse;
		wb_ack_out ##1 !wb_ack_out;
	endsequence
	property p_ack;
		s_req |=> s_pulse;
	endproperty
	a_ack: assert property (p_ack) else $error("ack is not one pulse after request");
	property p_idle;
		!wb_ack_out |-> wb_dat_out == '0;
	endproperty
	a_idle: assert property (p_idle) else $error("read data not zero outside ack");
	property p_oe_pair;
		serial_clk_out.oe == first_serial_pin_out.oe;
	endproperty
	a_oe_pair: assert property (p_oe_pair) else $error("serial clock enables differ");
	property p_half;
		serial_clk_out.oe && $changed(serial_clk_out.level) |=> $stable(serial_clk_out.level) || !serial_clk_out.oe;
	endproperty
	a_half: assert property (p_half) else $error("bit clock half period too short");
	property p_wait;
		lock_wait_out inside {[15'd1024:15'd16384]};
	endproperty
	a_wait: assert property (p_wait) else $error("lock wait out of range");
	property p_lvl_in;
		pin_level_out[0] |-> !pin_one_out.oe;
	endproperty
	a_lvl_in: assert property (p_lvl_in) else $error("sampled pin is driven");
	property p_sel_in;
		in_select_en_out[0] |-> !pin_one_out.oe;
	endproperty
	a_sel_in: assert property (p_sel_in) else $error("select pin is driven");
	property p_sel_lvl;
		(in_select_level_out & ~in_select_en_out) == 2'b00;
	endproperty
	a_sel_lvl: assert property (p_sel_lvl) else $error("select level without select");
endmodule
`default_nettype wire

// File: verif/gpfmc_partner.sv
`timescale 1ns/10ps
`default_nettype none
module gpfmc_partner
	import gpfmc_pkg::*;
(
	input wire logic       mclk_in,
	input wire gpfmc_pin_s bit_clk_in,
	input wire gpfmc_pin_s frame_clk_in,
	output var int         bit_period_out,
	output var int         bits_per_frame_out
);
	int   cnt = 0;
	int   bits = 0;
	logic bq = 1'b0;
	logic fq = 1'b0;
	logic br;
	logic fr;
	assign br = bit_clk_in.level && bit_clk_in.oe && !bq;
	assign fr = frame_clk_in.level && frame_clk_in.oe && !fq;
	always @(posedge mclk_in) begin
		bq <= bit_clk_in.level && bit_clk_in.oe;
		fq <= frame_clk_in.level && frame_clk_in.oe;
		cnt <= br ? 1 : cnt + 1;
		if (br)
			bit_period_out <= cnt;
		if (fr) begin
			bits_per_frame_out <= bits + int'(br);
			bits <= 0;
		end else
			bits <= bits + int'(br);
	end
endmodule
`default_nettype wire

// File: verif/test_gpfmc.sv
`timescale 1ns/10ps
`default_nettype none
module test_gpfmc import gpfmc_pkg::*;;
	logic mclk_in = 0, rst_in = 1, cyc = 0, stb = 0, we = 0, srd = 0, p1 = 0, p2 = 0;
	logic [7:0] adr = 0, amt = 8'h01, rsv;
	logic [31:0] dat = 0, r = 32'h1226, rdat;
	logic [3:0] tbl[6] = '{4'h0, 4'h1, 4'h2, 4'h7, 4'hf, 4'hc};
	gpfmc_stat_s st = '0;
	gpfmc_pin_s o1, o2, sclk, fpin;
	logic [1:0] lvl, sen, slv;
	logic ack, ql, lv;
	logic [WAIT_W-1:0] lw;
	int bper, bfr, mismatches = 0, checks = 0;
	logic [31:0] expq[$];
	gpfmc_top i_dut (.mclk_in, .rst_in, .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
		.wb_sel_in(4'hf), .wb_dat_in(dat), .wb_dat_out(rdat), .wb_ack_out(ack), .status_in(st),
		.automute_time_in(amt), .status_read_in(srd), .pin_one_in(p1), .pin_two_in(p2), .pin_one_out(o1),
		.pin_two_out(o2), .serial_clk_out(sclk), .first_serial_pin_out(fpin), .pin_level_out(lvl),
		.in_select_en_out(sen), .in_select_level_out(slv), .quick_lock_out(ql), .lock_wait_out(lw),
		.rsvd_nine_out(rsv));
	gpfmc_partner i_far (.mclk_in, .bit_clk_in(sclk), .frame_clk_in(fpin), .bit_period_out(bper),
		.bits_per_frame_out(bfr));
	initial begin
		forever #2 mclk_in = ~mclk_in;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic fexp(input logic [3:0] c, input gpfmc_stat_s s);
		case (c)
			4'h0: return s.automute && amt != 0;
			4'h1: return s.lock;
			4'h2: return s.min_volume;
			4'hf: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] %0t saw %h expected %h", $time, s, e);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge mclk_in);
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
		if (!w)
			expq.push_back({24'h0, e});
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= {24'h0, d};
		do @(posedge mclk_in); while (ack !== 1'b1);
		cyc <= 0;
		stb <= 0;
		@(posedge mclk_in);
	endtask
	task automatic clr;
		srd <= 1;
		wt(1);
		srd <= 0;
		wt(2);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge mclk_in) begin
		if (ack === 1'b1 && we === 1'b0 && expq.size() > 0)
			chk(rdat, expq.pop_front());
	end
	initial begin
		wt(30000);
		mismatches++;
		summarize();
	end
	initial begin
		int c;
		wt(2);
		rst_in <= 0;
		wt(1);
		wb(0, 8'h20, 0, 8'h10);
		wb(0, 8'h24, 0, 8'h22);
		wb(0, 8'h28, 0, 8'h05);
		wb(0, 8'h10, 0, 8'h00);
		r = lfsr(r);
		wb(1, 8'h24, r[7:0], 0);
		wb(0, 8'h24, 0, r[7:0]);
		chk(32'(rsv), 32'(r[7:0]));
		$display("registers done");
		for (c = 0; c < 16; c++) begin
			wb(1, 8'h28, {3'b000, c[0], c[3:0]}, 0);
			wt(2);
			chk(32'(lw), 16384 / (c + 1));
			chk(32'(ql), c[0]);
		end
		$display("lock wait done");
		for (c = 0; c < 12; c++) begin
			r = lfsr(r);
			st <= {r[2], r[1] | (c > 5), r[0]};
			amt <= (c > 5) ? 8'h00 : r[15:8] | 8'h01;
			wb(1, 8'h20, {tbl[c % 6], tbl[c % 6]}, 0);
			wt(2);
			chk(32'(o1), {fexp(tbl[c % 6], st), 1'b1});
			chk(32'(o2), {fexp(tbl[c % 6], st), 1'b1});
		end
		r = lfsr(r);
		p1 <= 1;
		p2 <= r[0];
		wb(1, 8'h20, 8'h88, 0);
		wt(3);
		chk({o1.oe, o2.oe, lvl}, {2'b00, r[0], 1'b1});
		wb(1, 8'h20, 8'h99, 0);
		wt(3);
		chk({sen, slv, lvl}, {2'b11, r[0], 1'b1, 2'b00});
		wb(1, 8'h20, 8'h33, 0);
		wt(2);
		lv = o1.level;
		wt(1);
		chk(o1.level ^ lv, 1);
		$display("pin functions done");
		st <= '0;
		amt <= 8'h01;
		for (c = 4; c < 7; c++) begin
			wb(1, 8'h20, {c[3:0], c[3:0]}, 0);
			clr();
			chk(o1.level, 0);
			st <= st ^ 3'b001;
			wt(3);
			chk(o1.level, c != 5);
			clr();
			chk(o1.level, 0);
			st <= st ^ 3'b010;
			wt(3);
			chk(o2.level, c != 4);
		end
		$display("interrupts done");
		for (c = 0; c < 4; c++) begin
			wb(1, 8'h28, {1'b1, c[1:0], 5'h00}, 0);
			wt(3000);
			chk({sclk.oe, fpin.oe}, 2'b11);
			chk(bper, 4 << (c - c / 3));
			chk(bfr, 64);
			wb(0, 8'hc0, 0, {1'b1, st.min_volume, st.automute, st.lock, 4'h3});
			wb(1, 8'h28, 8'h00, 0);
			wt(2);
			chk({sclk.oe, fpin.oe}, 2'b00);
		end
		$display("master clocks done");
		summarize();
	end
endmodule
bind gpfmc_top gpfmc_assertions #(.WB_DATA_W(WB_DATA_W)) i_chk (.mclk_in, .rst_in, .wb_cyc_in, .wb_stb_in,
	.wb_ack_out, .wb_dat_out, .pin_one_out, .serial_clk_out, .first_serial_pin_out, .pin_level_out,
	.in_select_en_out, .in_select_level_out, .lock_wait_out);
`default_nettype wire

// File: verilog/gpfmc_clkgen.sv
`timescale 1ns/10ps
`default_nettype none
module gpfmc_clkgen
	import gpfmc_pkg::*;
(
	input  wire logic       mclk_in,
	input  wire logic       rst_in,
	input  wire logic       enable_in,
	input  wire logic [1:0] div_sel_in,
	output logic            bit_clk_out,
	output logic            frame_clk_out
);

	typedef struct packed {
		logic [3:0] div_cnt;
		logic       bclk;
		logic [4:0] bit_cnt;
		logic       fclk;
	} gpfmc_cg_state_s;

	gpfmc_cg_state_s q;
	gpfmc_cg_state_s d;

	always_comb begin
		d = q;
		if (!enable_in) begin
			d = '0;
		end else if (q.div_cnt == gpfmc_half_period(div_sel_in) - 4'h1) begin
			// RL12 divided bit clock
			d.div_cnt = '0;
			d.bclk = !q.bclk;
			if (q.bclk) begin
				// RL13 frame every 64 bits
				d.bit_cnt = q.bit_cnt + 5'h1;
				if (q.bit_cnt == BITS_PER_HALF_FRAME) begin
					d.fclk = !q.fclk;
				end
			end
		end else begin
			d.div_cnt = q.div_cnt + 4'h1;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign bit_clk_out = q.bclk;
	assign frame_clk_out = q.fclk;

endmodule
`default_nettype wire

// File: verilog/gpfmc_top.sv
`timescale 1ns/10ps
`default_nettype none
module gpfmc_top
	import gpfmc_pkg::*;
#(
	parameter int unsigned WB_DATA_W = 32,
	parameter int unsigned WB_ADR_W  = 8
)
(
	input  wire logic                 mclk_in,
	input  wire logic                 rst_in,

	input  wire logic                 wb_cyc_in,
	input  wire logic                 wb_stb_in,
	input  wire logic                 wb_we_in,
	input  wire logic [WB_ADR_W-1:0]  wb_adr_in,
	input  wire logic [3:0]           wb_sel_in,
	input  wire logic [WB_DATA_W-1:0] wb_dat_in,
	output logic      [WB_DATA_W-1:0] wb_dat_out,
	output logic                      wb_ack_out,

	input  wire gpfmc_stat_s          status_in,
	input  wire logic [7:0]           automute_time_in,
	input  wire logic                 status_read_in,

	input  wire logic                 pin_one_in,
	input  wire logic                 pin_two_in,
	output gpfmc_pin_s                pin_one_out,
	output gpfmc_pin_s                pin_two_out,

	output gpfmc_pin_s                serial_clk_out,
	output gpfmc_pin_s                first_serial_pin_out,

	output logic [1:0]                pin_level_out,
	output logic [1:0]                in_select_en_out,
	output logic [1:0]                in_select_level_out,
	output logic                      quick_lock_out,
	output logic [WAIT_W-1:0]         lock_wait_out,
	output logic [7:0]                rsvd_nine_out
);

	// Index field of a bus byte address; bits above it must be zero
	localparam int unsigned IDX_LSB = 2;
	localparam int unsigned IDX_MSB = 7;
	localparam int unsigned MAP_TOP = IDX_MSB + 1;

	if (WB_DATA_W < REG_W) begin : g_chk_dw
		$error("Bus data narrower than registers");
	end
	if (WB_ADR_W < MAP_TOP) begin : g_chk_aw
		$error("Bus address too narrow for register map");
	end

	typedef struct packed {
		gpfmc_pin_func_s   pin_func;
		logic [7:0]        rsvd_nine;
		gpfmc_clk_master_s clk_master;
		logic              ack;
		logic [7:0]        rdata;
		logic              prev_lock;
		logic              prev_mute;
		logic [1:0]        irq;
		logic              ref_clk;
		gpfmc_pin_s        pin_one;
		gpfmc_pin_s        pin_two;
		gpfmc_pin_s        ser_clk;
		gpfmc_pin_s        ser_data;
		logic [1:0]        pin_level;
		logic [1:0]        in_sel_en;
		logic [1:0]        in_sel_level;
		logic [WAIT_W-1:0] lock_wait;
	} gpfmc_state_s;

	// Register named by a bus address
	typedef enum logic [2:0] {
		GPFMC_REG_NONE   = 3'b000,
		GPFMC_REG_PIN    = 3'b001,
		GPFMC_REG_RSVD   = 3'b010,
		GPFMC_REG_MASTER = 3'b011,
		GPFMC_REG_STATE  = 3'b100
	} gpfmc_reg_e;

	gpfmc_state_s q;
	gpfmc_state_s d;

	logic bit_clk;
	logic frame_clk;

	gpfmc_clkgen u_clkgen (
		.mclk_in       (mclk_in),
		.rst_in        (rst_in),
		.enable_in     (q.clk_master.master_en),
		.div_sel_in    (q.clk_master.div_sel),
		.bit_clk_out   (bit_clk),
		.frame_clk_out (frame_clk)
	);

	// Level and direction a pin takes for its function code
	function automatic gpfmc_pin_s pin_drive(
		input logic [3:0]  func,
		input gpfmc_stat_s stat,
		input logic        irq,
		input logic        ref_clk
	);
		gpfmc_pin_s p;
		p.oe = 1'b1;
		p.level = 1'b0;
		case (func)
			// RL3 automute status
			FN_AUTOMUTE: p.level = stat.automute;
			// RL4 lock status
			FN_LOCK:     p.level = stat.lock;
			// RL5 minimum volume
			FN_MIN_VOL:  p.level = stat.min_volume;
			// RL22 reference clock out
			FN_REF_CLK:  p.level = ref_clk;
			FN_INT_LOCK: p.level = irq;
			FN_INT_MUTE: p.level = irq;
			FN_INT_ANY:  p.level = irq;
			// RL22 constant levels
			FN_LOW:      p.level = 1'b0;
			FN_HIGH:     p.level = 1'b1;
			// RL9 input pins
			FN_INPUT:    p.oe = 1'b0;
			FN_IN_SEL:   p.oe = 1'b0;
			default:     p.level = 1'b0;
		endcase
		return p;
	endfunction

	// Interrupt flag update for one pin
	function automatic logic irq_next(
		input logic [3:0] func,
		input logic       flag,
		input logic       lock_chg,
		input logic       mute_chg,
		input logic       clear
	);
		logic set;
		set = 1'b0;
		case (func)
			// RL6 lock change
			FN_INT_LOCK: set = lock_chg;
			// RL7 automute change
			FN_INT_MUTE: set = mute_chg;
			// RL8 either change
			FN_INT_ANY:  set = lock_chg | mute_chg;
			default:     set = 1'b0;
		endcase
		if (func != FN_INT_LOCK && func != FN_INT_MUTE && func != FN_INT_ANY) begin
			irq_next = 1'b0;
		end else if (set) begin
			irq_next = 1'b1;
		end else if (clear) begin
			irq_next = 1'b0;
		end else begin
			irq_next = flag;
		end
	endfunction

	// Decode a bus byte address; out-of-map bits give no register
	function automatic gpfmc_reg_e reg_decode(input logic [WB_ADR_W-1:0] adr);
		logic [IDX_MSB-IDX_LSB:0] index;
		gpfmc_reg_e               sel;
		index = adr[IDX_MSB:IDX_LSB];
		sel = GPFMC_REG_NONE;
		if ((adr >> MAP_TOP) != '0) begin
			sel = GPFMC_REG_NONE;
		end else if (index == IDX_PIN_FUNC) begin
			sel = GPFMC_REG_PIN;
		end else if (index == IDX_RSVD_NINE) begin
			sel = GPFMC_REG_RSVD;
		end else if (index == IDX_CLK_MASTER) begin
			sel = GPFMC_REG_MASTER;
		end else if (index == IDX_PIN_STATE) begin
			sel = GPFMC_REG_STATE;
		end else begin
			sel = GPFMC_REG_NONE;
		end
		return sel;
	endfunction

	// Value a read of the named register returns
	function automatic logic [REG_W-1:0] read_mux(
		input gpfmc_reg_e       sel,
		input gpfmc_state_s     cur,
		input gpfmc_pin_state_s live
	);
		logic [REG_W-1:0] v;
		case (sel)
			GPFMC_REG_PIN:    v = cur.pin_func;
			GPFMC_REG_RSVD:   v = cur.rsvd_nine;
			GPFMC_REG_MASTER: v = cur.clk_master;
			GPFMC_REG_STATE:  v = live;
			default:          v = '0;
		endcase
		return v;
	endfunction

	// Register contents after a byte is written to the named register
	function automatic gpfmc_state_s write_reg(
		input gpfmc_reg_e       sel,
		input gpfmc_state_s     cur,
		input logic [REG_W-1:0] data
	);
		gpfmc_state_s nxt;
		nxt = cur;
		case (sel)
			// RL1 pin two field
			// RL2 pin one field
			GPFMC_REG_PIN:    nxt.pin_func = data;
			// RL21 reserved storage
			GPFMC_REG_RSVD:   nxt.rsvd_nine = data;
			// RL11 master enable
			// RL15 quick lock
			GPFMC_REG_MASTER: nxt.clk_master = data;
			default:          nxt = cur;
		endcase
		return nxt;
	endfunction

	// Live pin and status word shown in the read-only state register
	function automatic gpfmc_pin_state_s live_state(
		input gpfmc_state_s cur,
		input gpfmc_stat_s  stat
	);
		gpfmc_pin_state_s s;
		s.master_en = cur.clk_master.master_en;
		s.min_volume = stat.min_volume;
		s.automute = stat.automute;
		s.lock = stat.lock;
		s.pin_level = cur.pin_level;
		s.irq = cur.irq;
		return s;
	endfunction

	// A serial pin driven only while master mode is on
	function automatic gpfmc_pin_s serial_drive(input logic en, input logic level);
		gpfmc_pin_s p;
		p.oe = en;
		p.level = en && level;
		return p;
	endfunction

	// Level of a pin taken in only while it serves the given input code
	function automatic logic pin_sample(input logic [3:0] func, input gpfmc_func_e code, input logic level);
		return (func == code) && level;
	endfunction

	gpfmc_stat_s      stat;
	logic             lock_chg;
	logic             mute_chg;
	gpfmc_reg_e       rsel;
	logic             req;
	logic [7:0]       wbyte;
	gpfmc_pin_state_s pstate;

	always_comb begin
		stat = status_in;
		// RL23 automute gated by time setting
		stat.automute = status_in.automute && (automute_time_in != 8'h00);
		lock_chg = stat.lock != q.prev_lock;
		mute_chg = stat.automute != q.prev_mute;
		rsel = reg_decode(wb_adr_in);
		req = wb_cyc_in && wb_stb_in;
		wbyte = wb_dat_in[7:0];
		pstate = live_state(q, stat);
	end

	always_comb begin
		d = q;

		// Classic slave: answer one cycle after the request
		d.ack = req && !q.ack;
		if (req && !q.ack && !wb_we_in) begin
			d.rdata = read_mux(rsel, q, pstate);
		end else begin
			// Bus reads zero outside the acknowledged read
			d.rdata = '0;
		end

		// Write lands on the edge the master takes the answer
		if (req && q.ack && wb_we_in && wb_sel_in[0]) begin
			d = write_reg(rsel, d, wbyte);
		end

		d.prev_lock = stat.lock;
		d.prev_mute = stat.automute;
		d.irq[0] = irq_next(q.pin_func.pin_one_function, q.irq[0], lock_chg, mute_chg,
			status_read_in);
		d.irq[1] = irq_next(q.pin_func.pin_two_function, q.irq[1], lock_chg, mute_chg,
			status_read_in);

		d.ref_clk = !q.ref_clk;
		d.pin_one = pin_drive(q.pin_func.pin_one_function, stat, q.irq[0], q.ref_clk);
		d.pin_two = pin_drive(q.pin_func.pin_two_function, stat, q.irq[1], q.ref_clk);

		// RL9 sample input pins
		d.pin_level[0] = pin_sample(q.pin_func.pin_one_function, FN_INPUT, pin_one_in);
		d.pin_level[1] = pin_sample(q.pin_func.pin_two_function, FN_INPUT, pin_two_in);

		// RL10 input select steering
		d.in_sel_en[0] = q.pin_func.pin_one_function == FN_IN_SEL;
		d.in_sel_en[1] = q.pin_func.pin_two_function == FN_IN_SEL;
		d.in_sel_level[0] = pin_sample(q.pin_func.pin_one_function, FN_IN_SEL, pin_one_in);
		d.in_sel_level[1] = pin_sample(q.pin_func.pin_two_function, FN_IN_SEL, pin_two_in);

		// RL14 master drives serial pins
		d.ser_clk = serial_drive(q.clk_master.master_en, bit_clk);
		d.ser_data = serial_drive(q.clk_master.master_en, frame_clk);

		// RL17 lock wait count
		d.lock_wait = gpfmc_lock_wait(q.clk_master.lock_wait);
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			q <= '0;
			// RL20 register reset values
			q.pin_func <= PIN_FUNC_RST;
			q.clk_master <= CLK_MASTER_RST;
			// RL21 reserved reset
			q.rsvd_nine <= RSVD_NINE_RST;
			q.lock_wait <= gpfmc_lock_wait(CLK_MASTER_RST[3:0]);
			q.pin_one.oe <= 1'b1;
			q.pin_two.oe <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign wb_dat_out = {(WB_DATA_W-REG_W)'(0), q.rdata};
	assign wb_ack_out = q.ack;
	assign pin_one_out = q.pin_one;
	assign pin_two_out = q.pin_two;
	assign serial_clk_out = q.ser_clk;
	assign first_serial_pin_out = q.ser_data;
	assign pin_level_out = q.pin_level;
	assign in_select_en_out = q.in_sel_en;
	assign in_select_level_out = q.in_sel_level;
	assign quick_lock_out = q.clk_master.quick_lock;
	assign lock_wait_out = q.lock_wait;
	assign rsvd_nine_out = q.rsvd_nine;

endmodule
`default_nettype wire
